// File: core/pfsel_top.sv
// pin function select for ports 3..9 with an Avalon-MM register slave
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module pfsel_top
  import pfsel_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pads: port 3 pins 0..4,6,7 (index 5 unused), port 4, port 5, P83
  input wire logic [7:0] p3_pad_in,
  input wire logic [7:0] p4_pad_in,
  input wire logic [6:0] p5_pad_in,
  input wire logic p83_pad_in,
  output logic p34_pad_out,
  output logic p34_pad_oe,
  output logic p54_pad_out,
  output logic p54_pad_oe,
  output logic p55_pad_out,
  output logic p55_pad_oe,
  output logic p83_pad_out,
  output logic p83_pad_oe,
  // peripheral side
  input wire logic mtimer_io_ch0_a_out,
  input wire logic mtimer_io_ch0_a_oe,
  input wire logic mtimer_io_ch4_b_out,
  input wire logic mtimer_io_ch4_b_oe,
  input wire logic mtimer_io_ch4_c_out,
  input wire logic mtimer_io_ch4_c_oe,
  input wire logic mtimer_io_ch4_d_out,
  input wire logic mtimer_io_ch4_d_oe,
  input wire logic serial6_clock_out,
  input wire logic serial6_clock_oe,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_oe,
  input wire logic serial2_flow_or_select_out,
  input wire logic can0_transmit,
  output logic mtimer_io_ch0_a_in,
  output logic mtimer_io_ch4_b_in,
  output logic mtimer_io_ch4_c_in,
  output logic mtimer_io_ch4_d_in,
  output logic byte_timer3_clock_in,
  output logic byte_timer1_clock_in,
  output logic output_disable_request_10,
  output logic serial6_clock_in,
  output logic serial0_clock_in,
  output logic serial10_flow_or_select,
  output logic [15:0] irq_req,
  output logic [15:0] irq_req_ds_capable,
  output logic [7:0] analog_channel_en,
  output logic [7:0] analog_channel_0
);
  // ==========================================================
  // control registers
  logic [7:0] p3_ctl_q [0:7]; // only index 4 has storage; rest bit 6 only
  logic [7:0] p4_ctl_q [0:7];
  logic [7:0] p5_ctl_q [0:6];
  logic [7:0] p83_ctl_q;
  logic [31:0] rdata_q;
  logic wait_q;

  // decode: one access per two cycles, waitrequest low in second
  wire access = (avs_read | avs_write) & wait_q;
  // the write lands on the answer edge, while the master still holds it
  wire wr_en = avs_write & ~wait_q & avs_byteenable[0];
  // the p83 word sits past port 5, so seven address bits are needed
  wire [4:0] widx = avs_address[6:2];
  wire sel_p34 = widx == PFSEL_P34_OFS[6:2];
  wire sel_p4 = widx >= PFSEL_P4_OFS[6:2] && widx < PFSEL_P5_OFS[6:2];
  wire sel_p5 = widx >= PFSEL_P5_OFS[6:2] && widx < PFSEL_P83_OFS[6:2];
  wire sel_p83 = widx == PFSEL_P83_OFS[6:2];
  wire [2:0] p4_i = 3'(widx - PFSEL_P4_OFS[6:2]);
  wire [2:0] p5_i = 3'(widx - PFSEL_P5_OFS[6:2]);
  // byte lanes 1..3 carry nothing; the control byte rides lane 0
  wire [7:0] wbyte = avs_writedata[7:0];
  logic [7:0] rd_sel;
  always_comb
  begin
    // bits a register lacks read back as zero
    rd_sel = PFSEL_UNMAPPED[7:0];
    if (sel_p34)
      rd_sel = p3_ctl_q[4] & 8'h7F;
    else if (sel_p4)
      rd_sel = p4_ctl_q[p4_i];
    else if (sel_p5)
      rd_sel = p5_ctl_q[p5_i] & 8'h7F;
    else if (sel_p83)
      rd_sel = p83_ctl_q & 8'h3F;
  end

  // bus handshake; read data latched when waitrequest drops
  // readdata then stands until the next access is answered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= ~access;
      rdata_q <= access ? {24'h00_0000, rd_sel} : rdata_q;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // register writes; analog bit exists on port 4 only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++) p3_ctl_q[i] <= PFSEL_RESET;
      for (int i = 0; i < 8; i++) p4_ctl_q[i] <= PFSEL_RESET;
      for (int i = 0; i < 7; i++) p5_ctl_q[i] <= PFSEL_RESET;
      p83_ctl_q <= PFSEL_RESET;
    end
    else if (wr_en)
    begin
      // port 3 pins other than 4 have no register; their irq bits stay 0
      if (sel_p34)
        p3_ctl_q[4] <= wbyte & 8'h7F;
      if (sel_p4)
        p4_ctl_q[p4_i] <= wbyte;
      if (sel_p5)
        p5_ctl_q[p5_i] <= wbyte & 8'h7F;
      if (sel_p83)
        p83_ctl_q <= wbyte & 8'h3F;
    end
  end

  // ==========================================================
  // routing, registered so every output leaves a flip-flop
  wire [5:0] f34 = p3_ctl_q[4][5:0];
  wire [5:0] f54 = p5_ctl_q[4][5:0];
  wire [5:0] f55 = p5_ctl_q[5][5:0];
  wire [5:0] f83 = p83_ctl_q[5:0];
  logic [15:0] irq_d;
  logic [7:0] ana_en_d;
  always_comb
  begin
    irq_d = 16'h0000;
    ana_en_d = 8'h00;
    // port 3 pins 0..3 irq 0..3, pin 4 and pin 7 share irq 4
    for (int i = 0; i < 4; i++)
      irq_d[i] = p5_ctl_q[0][7] ? 1'b0 : 1'b0;
    // analog use takes a port 4 pin away from its interrupt line
    for (int i = 0; i < 8; i++)
    begin
      irq_d[8 + i] = p4_ctl_q[i][PFSEL_IRQ_BIT] & ~p4_ctl_q[i][PFSEL_ANA_BIT]
        & p4_pad_in[i];
      ana_en_d[i] = p4_ctl_q[i][PFSEL_ANA_BIT];
    end
    for (int i = 0; i < 4; i++)
      irq_d[i] = p3_ctl_q[i][PFSEL_IRQ_BIT] & p3_pad_in[i];
    irq_d[4] = (p3_ctl_q[4][PFSEL_IRQ_BIT] & p3_pad_in[4])
      | (p3_ctl_q[7][PFSEL_IRQ_BIT] & p3_pad_in[7]);
    irq_d[5] = p3_ctl_q[6][PFSEL_IRQ_BIT] & p3_pad_in[6];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_req <= 16'h0000;
      // the wake-capable map is fixed, yet still leaves a flop
      irq_req_ds_capable <= 16'hFF0F;
      analog_channel_en <= 8'h00;
      analog_channel_0 <= 8'h00;
    end
    else
    begin
      irq_req <= irq_d;
      irq_req_ds_capable <= 16'hFF0F;
      analog_channel_en <= ana_en_d;
      analog_channel_0 <= ana_en_d & p4_pad_in;
    end
  end

  // pad drivers; code zero or unknown code leaves the pad floating
  // oe low lets the outside level win on the pad
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p34_pad_out <= 1'b0;
      p34_pad_oe <= 1'b0;
      p54_pad_out <= 1'b0;
      p54_pad_oe <= 1'b0;
      p55_pad_out <= 1'b0;
      p55_pad_oe <= 1'b0;
      p83_pad_out <= 1'b0;
      p83_pad_oe <= 1'b0;
    end
    else
    begin
      case (f34)
        PFSEL_F_TIMER_IO:
        begin
          p34_pad_out <= mtimer_io_ch0_a_out;
          p34_pad_oe <= mtimer_io_ch0_a_oe;
        end
        PFSEL_F_SER_A:
        begin
          p34_pad_out <= serial6_clock_out;
          p34_pad_oe <= serial6_clock_oe;
        end
        PFSEL_F_SER_B:
        begin
          p34_pad_out <= serial0_clock_out;
          p34_pad_oe <= serial0_clock_oe;
        end
        default:
        begin
          p34_pad_out <= 1'b0;
          p34_pad_oe <= 1'b0;
        end
      endcase
      case (f54)
        PFSEL_F_TIMER_IO:
        begin
          p54_pad_out <= mtimer_io_ch4_b_out;
          p54_pad_oe <= mtimer_io_ch4_b_oe;
        end
        PFSEL_F_SER_B:
        begin
          p54_pad_out <= serial2_flow_or_select_out;
          p54_pad_oe <= 1'b1;
        end
        PFSEL_F_CAN:
        begin
          p54_pad_out <= can0_transmit;
          p54_pad_oe <= 1'b1;
        end
        default:
        begin
          p54_pad_out <= 1'b0;
          p54_pad_oe <= 1'b0;
        end
      endcase
      p55_pad_out <= (f55 == PFSEL_F_TIMER_IO) & mtimer_io_ch4_d_out;
      p55_pad_oe <= (f55 == PFSEL_F_TIMER_IO) & mtimer_io_ch4_d_oe;
      p83_pad_out <= (f83 == PFSEL_F_TIMER_IO) & mtimer_io_ch4_c_out;
      p83_pad_oe <= (f83 == PFSEL_F_TIMER_IO) & mtimer_io_ch4_c_oe;
    end
  end

  // peripheral inputs; deselected ones see a quiet zero, the two active-low ones a quiet one
  // the flop stage costs a cycle but keeps glitches off the inputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mtimer_io_ch0_a_in <= 1'b0;
      mtimer_io_ch4_b_in <= 1'b0;
      mtimer_io_ch4_c_in <= 1'b0;
      mtimer_io_ch4_d_in <= 1'b0;
      byte_timer3_clock_in <= 1'b0;
      byte_timer1_clock_in <= 1'b0;
      output_disable_request_10 <= 1'b1;
      serial6_clock_in <= 1'b0;
      serial0_clock_in <= 1'b0;
      serial10_flow_or_select <= 1'b1;
    end
    else
    begin
      mtimer_io_ch0_a_in <= (f34 == PFSEL_F_TIMER_IO) & p3_pad_in[4];
      byte_timer3_clock_in <= (f34 == PFSEL_F_TMR_CLK) & p3_pad_in[4];
      // active-low request idles high when not selected
      output_disable_request_10 <= (f34 != PFSEL_F_OUT_DIS) | p3_pad_in[4];
      serial6_clock_in <= (f34 == PFSEL_F_SER_A) & p3_pad_in[4];
      serial0_clock_in <= (f34 == PFSEL_F_SER_B) & p3_pad_in[4];
      mtimer_io_ch4_b_in <= (f54 == PFSEL_F_TIMER_IO) & p5_pad_in[4];
      byte_timer1_clock_in <= (f54 == PFSEL_F_TMR_CLK) & p5_pad_in[4];
      mtimer_io_ch4_d_in <= (f55 == PFSEL_F_TIMER_IO) & p5_pad_in[5];
      mtimer_io_ch4_c_in <= (f83 == PFSEL_F_TIMER_IO) & p83_pad_in;
      serial10_flow_or_select <= (f83 != PFSEL_F_SER_B) | p83_pad_in;
    end
  end
endmodule

// File: core/pfsel_pkg.sv
// package: register map and field layout of the port 3..9 pin function select
package pfsel_pkg;
  // ==========================================================
  // register byte addresses (word aligned)
  localparam logic [6:0] PFSEL_P34_OFS = 7'h00;
  localparam logic [6:0] PFSEL_P4_OFS = 7'h04; // eight words, 0x04..0x20
  localparam logic [6:0] PFSEL_P5_OFS = 7'h24; // seven words, 0x24..0x3C
  localparam logic [6:0] PFSEL_P83_OFS = 7'h40; // one word past port 5
  // ==========================================================
  // field layout of each control byte
  localparam int PFSEL_FUNC_LSB = 0;
  localparam int PFSEL_FUNC_W = 6;
  localparam int PFSEL_IRQ_BIT = 6;
  localparam int PFSEL_ANA_BIT = 7;
  localparam logic [7:0] PFSEL_RESET = 8'h00;
  // ==========================================================
  // function codes
  localparam logic [5:0] PFSEL_HIZ = 6'h00;
  localparam logic [5:0] PFSEL_F_TIMER_IO = 6'h01;
  localparam logic [5:0] PFSEL_F_TMR_CLK = 6'h05;
  localparam logic [5:0] PFSEL_F_OUT_DIS = 6'h07;
  localparam logic [5:0] PFSEL_F_SER_A = 6'h0A;
  localparam logic [5:0] PFSEL_F_SER_B = 6'h0B;
  localparam logic [5:0] PFSEL_F_CAN = 6'h10;
  // bus answer
  localparam logic [31:0] PFSEL_UNMAPPED = 32'h0000_0000;
endpackage

// File: test/pfsel_checker.sv
// checker: bus answer timing and pin routing of the selector
`timescale 1ns/1ns
module pfsel_checker
  import pfsel_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic p34_pad_oe,
  input wire logic [15:0] irq_req,
  input wire logic [15:0] irq_req_ds_capable,
  input wire logic [7:0] analog_channel_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // shadow byte; judged only after three quiet edges (sync slack)
  logic [7:0] s34_q;
  logic [1:0] age_q;
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire settled = age_q == 2'h3;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      s34_q <= 8'h00;
      age_q <= 2'h3;
    end
    else
    begin
      age_q <= wr_done ? 2'h0 : age_q + {1'b0, !settled};
      if (wr_done && avs_address == PFSEL_P34_OFS)
        s34_q <= avs_writedata[7:0];
    end
  // ==========
  // properties
  property p_answer; (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("late");
  property p_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("long");
  property p_idle; !avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_dscap; irq_req_ds_capable == 16'hFF0F; endproperty
  a_dscap: assert property (p_dscap) else $error("ds map");
  property p_p3irq; (irq_req[7:0] & 8'hEF) == 8'h00; endproperty
  a_p3irq: assert property (p_p3irq) else $error("p3 irq");
  property p_hiz34; settled && s34_q[5:0] == PFSEL_HIZ
    |-> !p34_pad_oe; endproperty
  a_hiz34: assert property (p_hiz34) else $error("p34 hiz");
  property p_irq34; settled && !s34_q[6] |-> !irq_req[4]; endproperty
  a_irq34: assert property (p_irq34) else $error("p34 irq");
  property p_ana; $stable(analog_channel_en) [*2]
    |-> (irq_req[15:8] & analog_channel_en) == 8'h00; endproperty
  a_ana: assert property (p_ana) else $error("analog irq");
  c_write: cover property (wr_done);
  c_drive: cover property (p34_pad_oe);
  c_irq: cover property (irq_req[15:8] != 8'h00);
endmodule
bind pfsel_top pfsel_checker u_chk (.*);

// File: test/pfsel_pad_model.sv
// pad model: outside drivers meet the block's own pad drivers
`timescale 1ns/1ns
module pfsel_pad_model
(
  input wire logic [7:0] ext,
  input wire logic p34_pad_out,
  input wire logic p34_pad_oe,
  input wire logic p54_pad_out,
  input wire logic p54_pad_oe,
  input wire logic p55_pad_out,
  input wire logic p55_pad_oe,
  input wire logic p83_pad_out,
  input wire logic p83_pad_oe,
  output logic [7:0] p3_pad_in,
  output logic [7:0] p4_pad_in,
  output logic [6:0] p5_pad_in,
  output logic p83_pad_in
);
  // a driven pad reads its own level, a released one the outside level
  assign p3_pad_in = {ext[7:5], p34_pad_oe ? p34_pad_out : ext[4], ext[3:0]};
  assign p4_pad_in = ext;
  assign p5_pad_in = {ext[6], p55_pad_oe ? p55_pad_out : ext[5],
    p54_pad_oe ? p54_pad_out : ext[4], ext[3:0]};
  assign p83_pad_in = p83_pad_oe ? p83_pad_out : ext[0];
endmodule

// File: test/pfsel_top_test.sv
// self-checking bench for the pin function selector
`timescale 1ns/1ns
module pfsel_top_test
  import pfsel_pkg::*;
  ;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, oe;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] p3_pad_in, p4_pad_in, pat, ext, n8, m;
  logic [6:0] p5_pad_in;
  logic [4:0] oh;
  logic p83_pad_in, p34_pad_out, p34_pad_oe, p54_pad_out, p54_pad_oe;
  logic p55_pad_out, p55_pad_oe, p83_pad_out, p83_pad_oe, can0_transmit;
  logic mtimer_io_ch0_a_out, mtimer_io_ch4_b_out, mtimer_io_ch4_c_out;
  logic mtimer_io_ch4_d_out, serial6_clock_out, serial0_clock_out;
  logic mtimer_io_ch0_a_oe, mtimer_io_ch4_b_oe, mtimer_io_ch4_c_oe;
  logic mtimer_io_ch4_d_oe, serial6_clock_oe, serial0_clock_oe;
  logic serial2_flow_or_select_out, serial10_flow_or_select;
  logic mtimer_io_ch0_a_in, mtimer_io_ch4_b_in, mtimer_io_ch4_c_in;
  logic mtimer_io_ch4_d_in, byte_timer3_clock_in, byte_timer1_clock_in;
  logic output_disable_request_10, serial6_clock_in, serial0_clock_in;
  logic [15:0] irq_req, irq_req_ds_capable;
  logic [7:0] analog_channel_en, analog_channel_0;
  logic [5:0] c34 [6] = '{PFSEL_HIZ, PFSEL_F_TIMER_IO, PFSEL_F_TMR_CLK,
    PFSEL_F_OUT_DIS, PFSEL_F_SER_A, PFSEL_F_SER_B};
  logic [5:0] c54 [5] = '{PFSEL_HIZ, PFSEL_F_TIMER_IO, PFSEL_F_TMR_CLK,
    PFSEL_F_SER_B, PFSEL_F_CAN};
  logic [3:0] e54 [5] = '{4'h0, 4'hE, 4'h1, 4'h8, 4'hC};
  int failures, cmp_count, i;
  // peripheral outputs follow the pattern byte, one shared enable
  assign {can0_transmit, serial2_flow_or_select_out, serial0_clock_out,
    serial6_clock_out, mtimer_io_ch4_d_out, mtimer_io_ch4_c_out,
    mtimer_io_ch4_b_out, mtimer_io_ch0_a_out} = pat;
  assign {mtimer_io_ch0_a_oe, mtimer_io_ch4_b_oe, mtimer_io_ch4_c_oe,
    mtimer_io_ch4_d_oe, serial6_clock_oe, serial0_clock_oe} = {6{oe}};
  pfsel_top dut (.*);
  pfsel_pad_model far (.*);
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // one bus access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    // no local limit: a slave that never answers meets the watchdog
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check("readback", {8'h00, e}, {8'h00, q});
  endtask
  // routing lands one edge after a write; pads add slack
  task automatic settle;
    repeat (5) @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog, far beyond the roughly 600 cycles of the run
  initial
  begin
    #200000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    {failures, cmp_count} = '0;
    {rst_n, avs_read, avs_write, oe} = 4'h0;
    {avs_address, avs_writedata, pat, ext} = '0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // reset value, byte masks per word, unmapped word last
    for (i = 0; i < 18; i++)
    begin
      m = i > 16 ? 8'h00 : i == 16 ? 8'h3F : i > 8 || i == 0 ? 8'h7F : 8'hFF;
      rd(7'(i * 4), 8'h00);
      wr(7'(i * 4), 8'hFF);
      rd(7'(i * 4), m);
      wr(7'(i * 4), 8'h00);
    end
    $display("test registers done");
    for (i = 0; i < 12; i++)
    begin
      oh = i < 2 ? 5'h00 : 5'h10 >> (i / 2 - 1);
      wr(PFSEL_P34_OFS, {2'h0, c34[i / 2]});
      ext <= {3'h0, i[0], 4'h0};
      settle;
      check("p34 route", {11'h000, i[0] ? oh | 5'h04 : 5'h04 & ~oh},
        {11'h000, mtimer_io_ch0_a_in, byte_timer3_clock_in,
        output_disable_request_10, serial6_clock_in,
        serial0_clock_in});
    end
    wr(PFSEL_P34_OFS, 8'h41);
    pat <= 8'h01;
    oe <= 1'b1;
    settle;
    check("p34 drive", 16'hC010,
      {p34_pad_oe, p34_pad_out, irq_req[13:0]});
    wr(PFSEL_P34_OFS, 8'h00);
    ext <= 8'hFF;
    $display("test port 3 done");
    for (i = 0; i < 16; i++)
    begin
      n8 = 8'h01 << i[2:0];
      wr(7'(PFSEL_P4_OFS + i[2:0] * 4), {i[3], 7'h40});
      settle;
      check("irq", {i[3] ? 8'h00 : n8, 8'h00}, irq_req);
      check("analog", i[3] ? {n8, n8} : 16'h0000,
        {analog_channel_en, analog_channel_0});
      wr(7'(PFSEL_P4_OFS + i[2:0] * 4), 8'h00);
    end
    $display("test port 4 done");
    pat <= 8'h82;
    for (i = 0; i < 5; i++)
    begin
      wr(PFSEL_P5_OFS + 6'h10, {2'h0, c54[i]});
      settle;
      check("p54", {12'h000, e54[i]}, {12'h000, p54_pad_oe, p54_pad_oe &
        p54_pad_out, mtimer_io_ch4_b_in, byte_timer1_clock_in});
    end
    pat <= 8'h0C;
    wr(PFSEL_P5_OFS + 6'h14, 8'h01);
    wr(PFSEL_P83_OFS, 8'h01);
    settle;
    check("timer 4c 4d", 16'h003F, {10'h000, p55_pad_oe, p55_pad_out,
      p83_pad_oe, p83_pad_out, mtimer_io_ch4_d_in,
      mtimer_io_ch4_c_in});
    wr(PFSEL_P83_OFS, 8'h0B);
    wr(PFSEL_P5_OFS + 6'h14, 8'h00);
    ext <= 8'h00;
    settle;
    check("p83 p55", 16'h0, {13'h0, p83_pad_oe, serial10_flow_or_select,
      p55_pad_oe});
    $display("test ports 5 and 8 done");
    report_and_stop;
  end
endmodule
